// File: design/iox_consts.vh
// Constants for the sixteen-line serial port expander.
// Assumes a 20 MHz system clock sampling the serial lines.
`ifndef IOX_CONSTS_VH
`define IOX_CONSTS_VH
// Fixed upper four bits of the slave address
`define IOX_ADDR_FIXED 4'h4
// Port value after reset: all lines high
`define IOX_PORT_RESET 16'hFFFF
// Bits in a byte
`define IOX_BYTE_BITS 4'h8
// Interrupt valid delay in ns, and in cycles of the 50 ns clock
`define IOX_IRQ_VALID_NS 4000
`define IOX_CLK_NS 50
`define IOX_IRQ_VALID_CYC (`IOX_IRQ_VALID_NS / `IOX_CLK_NS)
`endif

// File: design/iox_sync.v
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module iox_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire clock_i,
    input wire srst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second
    always @(posedge clock_i)
    begin
        if (srst_i)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // iox_sync

// File: design/iox_irq.v
// Change detector driving the active-low interrupt.
// Assumes synchronised port levels and a refresh strobe that may stay high for five cycles.
`timescale 1ns/1ps
`include "iox_consts.vh"
module iox_irq (
    input wire clock_i,
    input wire srst_i,
    input wire [15:0] port_lvl_i,
    input wire refresh_i,
    output wire irq_n_o
);
    reg [15:0] snap_q;
    reg [7:0] cnt_q;
    reg irq_n_q;
    wire diff;

    assign diff = |(snap_q ^ port_lvl_i);

    // Snapshot refreshed on each refresh_i pulse; mismatch raises interrupt after delay
    always @(posedge clock_i)
    begin
        if (srst_i)
        begin
            snap_q <= `IOX_PORT_RESET;
            cnt_q <= 8'h00;
            irq_n_q <= 1'b1;
        end
        else if (refresh_i)
        begin
            snap_q <= port_lvl_i;
            cnt_q <= 8'h00;
            irq_n_q <= 1'b1;
        end
        else if (!diff)
        begin
            cnt_q <= 8'h00;
            irq_n_q <= 1'b1;
        end
        else if (cnt_q >= `IOX_IRQ_VALID_CYC - 2)
            irq_n_q <= 1'b0;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    assign irq_n_o = irq_n_q;
endmodule // iox_irq

// File: design/iox_top.v
// Serial-bus slave driving sixteen quasi-bidirectional port lines.
// Assumes scl/sda are pins sampled by a 20 MHz clock; open-drain outputs
// are resolved outside, enable high meaning the line is pulled low.
`timescale 1ns/1ps
`include "iox_consts.vh"
module iox_top (
    input wire clock_i,
    input wire srst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_oe_o,
    input wire addr_select_bit0_i,
    input wire addr_select_bit1_i,
    input wire addr_select_bit2_i,
    input wire [7:0] low_port_byte_i,
    input wire [7:0] high_port_byte_i,
    output reg [7:0] low_port_byte_o,
    output reg [7:0] high_port_byte_o,
    output reg [15:0] port_low_oe_o,
    output reg [15:0] strong_pullup_boost_o,
    output wire irq_n_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_WRITE = 3'h2;
    localparam ST_READ = 3'h3;
    localparam ST_RACK = 3'h4;
    localparam ST_IGNORE = 3'h5;

    wire scl_s;
    wire sda_s;
    wire [2:0] sel_s;
    wire [15:0] port_s;
    wire irq_n;
    reg scl_q;
    reg sda_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg ack_q;
    reg half_q;
    reg [7:0] low_hold_q;
    reg [15:0] tx_q;
    reg [15:0] out_q;
    reg refresh_q;
    reg [3:0] settle_q;
    wire refresh_w;
    wire scl_rise;
    wire scl_fall;
    wire start_c;
    wire stop_c;
    wire [7:0] byte_in;

    // Pin synchronisers
    iox_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i({scl_i, sda_i}),
        .sync_o({scl_s, sda_s})
    );

    iox_sync #(.W(19), .INIT(19'h7FFFF)) u_pin_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i({addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i,
            high_port_byte_i, low_port_byte_i}),
        .sync_o({sel_s, port_s})
    );

    // Change detector
    iox_irq u_irq (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .port_lvl_i(port_s),
        .refresh_i(refresh_w),
        .irq_n_o(irq_n)
    );

    assign irq_n_o = irq_n;

    // Refresh stretched until new port levels have crossed the synchroniser.
    // Without it a write would see its own output change as an input edge
    // and raise the interrupt some cycles later.
    always @(posedge clock_i)
    begin
        if (srst_i)
            settle_q <= 4'h0;
        else
            settle_q <= {settle_q[2:0], refresh_q};
    end

    // Snapshot follows the pins for the whole settling window
    assign refresh_w = refresh_q | (|settle_q);

    // Bus event detection
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_c = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
    assign byte_in = {shift_q[6:0], sda_s};

    // Address match check
    function addr_hit;
        input [7:0] b;
        input [2:0] sel;
        begin
            addr_hit = (b[7:4] == `IOX_ADDR_FIXED) && (b[3:1] == sel);
        end
    endfunction

    // Index of the read bit that goes out after k bits of the byte.
    // Low byte uses bits 7..0 of the sample, high byte bits 15..8.
    function [3:0] tx_index;
        input hi;
        input [3:0] k;
        begin
            tx_index = {hi, ~k[2:0]}; // MSB first within each byte
        end
    endfunction

    // Delayed copies for edge finding
    always @(posedge clock_i)
    begin
        if (srst_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Serial protocol engine
    always @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            half_q <= 1'b0;
            low_hold_q <= 8'h00;
            tx_q <= 16'h0000;
            out_q <= `IOX_PORT_RESET;
            sda_oe_o <= 1'b0;
            refresh_q <= 1'b0;
        end
        else
        begin
            refresh_q <= 1'b0;
            if (start_c)
            begin
                state_q <= ST_ADDR;
                bit_q <= 4'h0;
                ack_q <= 1'b0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_c)
            begin
                state_q <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else if (scl_rise && !ack_q && bit_q < `IOX_BYTE_BITS)
            begin
                shift_q <= byte_in;
                bit_q <= bit_q + 4'h1;
            end
            else if (scl_rise && ack_q && state_q == ST_READ)
            begin
                // Master answer to a transmitted byte
                if (sda_s)
                    state_q <= ST_IGNORE;
                else
                    state_q <= ST_RACK;
            end
            else if (scl_fall)
            begin
                if (ack_q)
                begin
                    // End of acknowledge slot
                    ack_q <= 1'b0;
                    bit_q <= 4'h0;
                    sda_oe_o <= 1'b0;
                    if (state_q == ST_RACK)
                        state_q <= ST_READ;
                    if (state_q == ST_RACK || state_q == ST_READ)
                    begin
                        // Next read byte on the line
                        if (half_q)
                            sda_oe_o <= ~tx_q[15];
                        else
                        begin
                            tx_q <= {port_s[15:8], port_s[7:0]};
                            sda_oe_o <= ~port_s[7];
                        end
                    end
                    if (state_q == ST_IGNORE)
                        sda_oe_o <= 1'b0;
                end
                else if (bit_q == `IOX_BYTE_BITS)
                begin
                    // Eighth bit done: open acknowledge slot
                    ack_q <= 1'b1;
                    sda_oe_o <= 1'b0;
                    case (state_q)
                        ST_ADDR:
                        begin
                            if (addr_hit(shift_q, sel_s))
                            begin
                                sda_oe_o <= 1'b1;
                                half_q <= 1'b0;
                                refresh_q <= shift_q[0];
                                state_q <= shift_q[0] ? ST_RACK : ST_WRITE;
                            end
                            else
                                state_q <= ST_IGNORE;
                        end
                        ST_WRITE:
                        begin
                            sda_oe_o <= 1'b1;
                            half_q <= ~half_q;
                            if (!half_q)
                                low_hold_q <= shift_q;
                            else
                            begin
                                out_q <= {shift_q, low_hold_q};
                                refresh_q <= 1'b1;
                            end
                        end
                        ST_READ:
                        begin
                            half_q <= ~half_q;
                            if (half_q)
                                refresh_q <= 1'b1;
                        end
                        default:
                            state_q <= ST_IGNORE;
                    endcase
                end
                else if (state_q == ST_READ && bit_q != 4'h0)
                begin
                    // Shift out next bit, low byte then high byte
                    sda_oe_o <= ~tx_q[tx_index(half_q, bit_q)];
                end
            end
        end
    end

    // Port drivers and transient pull-up
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_port
            always @(posedge clock_i)
            begin
                if (srst_i)
                begin
                    port_low_oe_o[gi] <= 1'b0;
                    strong_pullup_boost_o[gi] <= 1'b0;
                end
                else
                begin
                    port_low_oe_o[gi] <= ~out_q[gi];
                    if (scl_fall)
                        strong_pullup_boost_o[gi] <= 1'b0;
                    else if (state_q == ST_WRITE && scl_fall == 1'b0 && ack_q && half_q == 1'b0
                        && out_q[gi] && port_low_oe_o[gi])
                        strong_pullup_boost_o[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Latched port value as written (out_q), not the pin levels
    always @(posedge clock_i)
    begin
        if (srst_i)
        begin
            low_port_byte_o <= 8'hFF;
            high_port_byte_o <= 8'hFF;
        end
        else
        begin
            low_port_byte_o <= out_q[7:0];
            high_port_byte_o <= out_q[15:8];
        end
    end
endmodule // iox_top

// File: tb/iox_master.sv
// Serial-bus master model driving the expander's clock and data lines.
// Assumes a pull-up on the data line; the clock idles high between frames.
`timescale 1ns/1ps
module iox_master (
    input wire sda_i,
    output logic scl_o = 1'b1,
    output logic sda_oe_o = 1'b0
);
    // One bit slot: data set after the fall, sampled in mid high
    task automatic slot(input logic v, output logic s);
        #20 sda_oe_o = !v;
        #230 scl_o = 1'b1;
        #75 s = sda_i;
        #75 scl_o = 1'b0;
    endtask
    // Data falls while the clock is high
    task automatic start();
        sda_oe_o = 1'b1;
        #150 scl_o = 1'b0;
    endtask
    // Data rises while the clock is high, then bus free time
    task automatic stop();
        #20 sda_oe_o = 1'b1;
        #230 scl_o = 1'b1;
        #150 sda_oe_o = 1'b0;
        #500;
    endtask
    // Byte out MSB first, then a released acknowledge slot
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            slot(b[i], s);
        slot(1'b1, s);
        ack = !s;
    endtask
    // Byte in, then acknowledge unless it is the last one wanted
    task automatic get_byte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            slot(1'b1, s);
            b[i] = s;
        end
        slot(last, s);
    endtask
endmodule // iox_master

// File: tb/iox_top_asserts.sv
// Checker on the expander top's ports.
// Assumes the pins are sampled by the block's own clock.
`timescale 1ns/1ps
module iox_chk (
    input wire clock_i,
    input wire srst_i,
    input wire scl_i,
    input wire sda_oe_o,
    input wire [7:0] low_port_byte_i,
    input wire [7:0] high_port_byte_i,
    input wire [7:0] low_port_byte_o,
    input wire [7:0] high_port_byte_o,
    input wire [15:0] port_low_oe_o,
    input wire [15:0] strong_pullup_boost_o,
    input wire irq_n_o
);
    wire [15:0] out_w = {high_port_byte_o, low_port_byte_o};
    wire [15:0] pin_w = {high_port_byte_i, low_port_byte_i};
    wire [15:0] bst_w = strong_pullup_boost_o;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // Reset state and bus-side timing
    property p_rst;
        $fell(srst_i) |-> out_w == 16'hFFFF && port_low_oe_o == 16'h0000 && bst_w == 16'h0000
            && irq_n_o && !sda_oe_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_hold;
        scl_i && $past(scl_i) |-> $stable(sda_oe_o);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved in clock high");
    property p_drv_low;
        $rose(sda_oe_o) |-> !scl_i;
    endproperty
    a_drv_low: assert property (p_drv_low) else $error("drive began in clock high");
    // Port drive follows the latched value
    property p_oe;
        $changed(out_w) |-> ##[0:2] port_low_oe_o == ~out_w;
    endproperty
    a_oe: assert property (p_oe) else $error("pin drive mismatch");
    property p_bst_off;
        |bst_w && $fell(scl_i) |-> ##[1:6] bst_w == 16'h0000;
    endproperty
    a_bst_off: assert property (p_bst_off) else $error("boost not cleared");
    property p_bst_hi;
        $rose(|bst_w) |-> ##[0:2] (bst_w & ~out_w) == 16'h0000;
    endproperty
    a_bst_hi: assert property (p_bst_hi) else $error("boost on a low line");
    // Interrupt timing
    property p_irq_dly;
        $changed(pin_w) && irq_n_o |=> irq_n_o [*8];
    endproperty
    a_irq_dly: assert property (p_irq_dly) else $error("interrupt too early");
    property p_irq_wr;
        $changed(out_w) |-> ##[0:4] irq_n_o;
    endproperty
    a_irq_wr: assert property (p_irq_wr) else $error("interrupt kept on write");
endmodule // iox_chk
bind iox_top iox_chk u_iox_chk (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .low_port_byte_i(low_port_byte_i), .high_port_byte_i(high_port_byte_i),
    .low_port_byte_o(low_port_byte_o), .high_port_byte_o(high_port_byte_o),
    .port_low_oe_o(port_low_oe_o), .strong_pullup_boost_o(strong_pullup_boost_o),
    .irq_n_o(irq_n_o)
);

// File: tb/test_i2c_sixteen_bit_port_expander.sv
// Self-checking bench for the sixteen-line serial port expander.
// Assumes the design and its constants header are on the include path.
`timescale 1ns/1ps
`include "iox_consts.vh"
module test_i2c_sixteen_bit_port_expander;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [2:0] sel_q = 3'h0;
    logic [15:0] ext_q = 16'h0000;
    logic [15:0] out_q = `IOX_PORT_RESET;
    logic a;
    int seed = 32'h7b6a63d5;
    int err_count = 0;
    int checks = 0;
    wire scl_w, m_oe_w, oe_w, irq_n_w;
    wire [7:0] lo_w, hi_w;
    wire [15:0] drv_w, bst_w;
    // Open-drain lines: pull-up unless some party pulls low
    wire sda_w = !(m_oe_w || oe_w);
    wire [15:0] pin_w = ~(drv_w | ext_q);
    iox_top u_iox_top (
        .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(oe_w),
        .addr_select_bit0_i(sel_q[0]), .addr_select_bit1_i(sel_q[1]),
        .addr_select_bit2_i(sel_q[2]), .low_port_byte_i(pin_w[7:0]),
        .high_port_byte_i(pin_w[15:8]), .low_port_byte_o(lo_w), .high_port_byte_o(hi_w),
        .port_low_oe_o(drv_w), .strong_pullup_boost_o(bst_w), .irq_n_o(irq_n_w)
    );
    iox_master u_iox_master (.sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(m_oe_w));
    always #25 clock_i = !clock_i;
    function automatic logic [7:0] adr(input logic [2:0] sel, input logic dir);
        return {`IOX_ADDR_FIXED, sel, dir};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    // Write n pairs, first one given, then an optional lone byte
    task automatic wr(input int n, input logic [15:0] v, input logic odd);
        u_iox_master.start();
        u_iox_master.put_byte(adr(sel_q, 1'b0), a);
        check(16'(a), 16'h0001);
        for (int i = 0; i < n; i++)
        begin
            u_iox_master.put_byte(v[7:0], a);
            check({hi_w, lo_w, 15'h0000, a}, {out_q, 16'h0001});
            u_iox_master.put_byte(v[15:8], a);
            cyc(4);
            out_q = v;
            check({hi_w, lo_w, ~drv_w, 15'h0000, a}, {v, v, 16'h0001});
            check(16'(irq_n_w), 16'h0001);
            v = 16'($random(seed));
        end
        if (odd)
            u_iox_master.put_byte(v[7:0], a);
        u_iox_master.stop();
        check({hi_w, lo_w}, out_q);
    endtask
    // Read n pairs, last high byte refused
    task automatic rd(input int n);
        logic [15:0] d;
        u_iox_master.start();
        u_iox_master.put_byte(adr(sel_q, 1'b1), a);
        check(16'(a), 16'h0001);
        for (int i = 0; i < n; i++)
        begin
            u_iox_master.get_byte(d[7:0], 1'b0);
            u_iox_master.get_byte(d[15:8], i == n - 1);
            check(d, out_q & ~ext_q);
        end
        cyc(4);
        check(16'(oe_w), 16'h0000);
        u_iox_master.stop();
        check(16'(irq_n_w), 16'h0001);
    endtask
    task automatic irq_after(input logic [15:0] e);
        ext_q = e;
        cyc(`IOX_IRQ_VALID_CYC + 10);
        check(16'(irq_n_w), 16'h0000);
    endtask
    initial
    begin
        repeat (60000) @(posedge clock_i);
        err_count++;
        wrap_up();
    end
    initial
    begin
        cyc(3);
        srst_i = 1'b0;
        sel_q = $random(seed);
        cyc(4);
        check({hi_w, lo_w, drv_w | bst_w}, {`IOX_PORT_RESET, 16'h0000});
        wr(4, 16'h00FF, 1'b1);
        wr(2, 16'h0000, 1'b0);
        // Foreign address: no acknowledge, outputs untouched
        u_iox_master.start();
        u_iox_master.put_byte(adr(sel_q ^ 3'h1, 1'b0), a);
        check(16'(a), 16'h0000);
        u_iox_master.put_byte(8'hFF, a);
        u_iox_master.stop();
        check({hi_w, lo_w}, out_q);
        wr(1, 16'hFFFF, 1'b0);
        irq_after(16'h0001 | 16'($random(seed)));
        ext_q = 16'h0000;
        cyc(`IOX_IRQ_VALID_CYC + 10);
        check(16'(irq_n_w), 16'h0001);
        irq_after(16'h8000 | 16'($random(seed)));
        rd(2);
        irq_after(ext_q ^ 16'h0100);
        wr(1, 16'hFFFF, 1'b0);
        rd(1);
        wrap_up();
    end
endmodule // test_i2c_sixteen_bit_port_expander
